// ### shared/dss_defines.svh
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// register byte offsets
`define DSS_OFF_INSTR 8'h00
`define DSS_OFF_STATUS 8'h04
`define DSS_OFF_CCR 8'h08
`define DSS_OFF_EA_VAL 8'h0c
`define DSS_OFF_EA_ADDR 8'h10
`define DSS_OFF_RESULT 8'h14
`define DSS_DREG_PAGE 3'h2
`define DSS_AREG_PAGE 3'h3

// opcode fields
`define DSS_F_CLASS 15:12
`define DSS_F_REG_HI 11:9
`define DSS_F_COND 11:8
`define DSS_F_OPMODE 8:6
`define DSS_F_BCD_FIX 8:4
`define DSS_F_SCC_FIX 7:6
`define DSS_F_MODE 5:3
`define DSS_F_RM 3
`define DSS_F_REG_LO 2:0

// opcode codes
`define DSS_CLS_BCD 4'h8
`define DSS_CLS_SCC 4'h5
`define DSS_CLS_SUB 4'h9
`define DSS_BCD_FIX 5'h10
`define DSS_SCC_FIX 2'h3
`define DSS_MODE_DREG 3'h0
`define DSS_MODE_AREG 3'h1
`define DSS_MODE_EXT 3'h7
`define DSS_EXT_IMM 3'h4
`define DSS_SZ_BYTE 2'h0
`define DSS_SZ_WORD 2'h1
`define DSS_SZ_ILL 2'h3
`define DSS_BCD_ADJ 5'h06

// reset values
`define DSS_CCR_RST 5'h00
`define DSS_WORD_RST 32'h0000_0000
`define DSS_INSTR_RST 16'h0000

`endif

// ### shared/dss_pkg.sv
package dss_pkg;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } dss_ccr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_RD_SRC, ST_RD_DST, ST_CALC, ST_WRITE}
    dss_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dss_mem_req_t;
endpackage : dss_pkg

// ### rtl/dss_exec_unit.sv
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`include "dss_defines.svh"
module dss_exec_unit (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output dss_pkg::dss_mem_req_t o_mem,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_ack
);

  dss_pkg::dss_state_t st_r;
  dss_pkg::dss_ccr_t ccr_r;
  dss_pkg::dss_mem_req_t mem_r;
  logic [15:0] instr_r;
  logic [31:0] d_r [8];
  logic [31:0] a_r [8];
  logic [31:0] ea_val_r, ea_addr_r, res_r, op_s_r, op_d_r, wb_dat_r;
  logic err_r, rd_seen_r, ack_r;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // sixteen condition tests
  function automatic logic dss_cond(input logic [3:0] cc, input dss_pkg::dss_ccr_t f);
    logic nv;
    nv = f.n ^ f.v;
    case (cc)
      4'h0: dss_cond = 1'b1;
      4'h1: dss_cond = 1'b0;
      4'h2: dss_cond = !f.c && !f.z;
      4'h3: dss_cond = f.c || f.z;
      4'h4: dss_cond = !f.c;
      4'h5: dss_cond = f.c;
      4'h6: dss_cond = !f.z;
      4'h7: dss_cond = f.z;
      4'h8: dss_cond = !f.v;
      4'h9: dss_cond = f.v;
      4'ha: dss_cond = !f.n;
      4'hb: dss_cond = f.n;
      4'hc: dss_cond = !nv;
      4'hd: dss_cond = nv;
      4'he: dss_cond = !f.z && !nv;
      default: dss_cond = f.z || nv;
    endcase
  endfunction : dss_cond

  // size-aware merge, upper register bits survive short ops
  function automatic logic [31:0] dss_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [1:0] sz);
    case (sz)
      `DSS_SZ_BYTE: dss_merge = {old[31:8], nw[7:0]};
      `DSS_SZ_WORD: dss_merge = {old[31:16], nw[15:0]};
      default: dss_merge = nw;
    endcase
  endfunction : dss_merge

  // --------------------------------------------------------------
  // opcode decode
  // --------------------------------------------------------------
  wire [3:0] f_class = instr_r[`DSS_F_CLASS];
  wire [2:0] f_rhi = instr_r[`DSS_F_REG_HI];
  wire [2:0] f_opm = instr_r[`DSS_F_OPMODE];
  wire [2:0] f_mode = instr_r[`DSS_F_MODE];
  wire [2:0] f_rlo = instr_r[`DSS_F_REG_LO];
  wire f_rm = instr_r[`DSS_F_RM];
  wire is_decimal_subtract_extend = f_class == `DSS_CLS_BCD && instr_r[`DSS_F_BCD_FIX] == `DSS_BCD_FIX;
  wire is_scc = f_class == `DSS_CLS_SCC && instr_r[`DSS_F_SCC_FIX] == `DSS_SCC_FIX;
  wire is_sub = f_class == `DSS_CLS_SUB && f_opm[1:0] != `DSS_SZ_ILL;
  wire ea_ext = f_mode == `DSS_MODE_EXT;
  wire ea_abs = ea_ext && f_rlo[2:1] == 2'h0;
  wire ea_imm = ea_ext && f_rlo == `DSS_EXT_IMM;
  wire ea_pc = ea_ext && f_rlo[2:1] == 2'h1;
  wire ea_memalt = (!ea_ext && f_mode[2:1] != 2'h0) || ea_abs;
  wire sub_to_reg = !f_opm[2];
  wire [1:0] sz = is_sub ? f_opm[1:0] : `DSS_SZ_BYTE;
  wire scc_ok = f_mode == `DSS_MODE_DREG || ea_memalt;
  wire src_ok = !ea_ext || ea_abs || ea_imm || ea_pc;
  wire byte_an = f_mode == `DSS_MODE_AREG && sz == `DSS_SZ_BYTE;
  wire sub_ok = sub_to_reg ? src_ok && !byte_an : ea_memalt;
  wire legal = is_decimal_subtract_extend || (is_scc && scc_ok) || (is_sub && sub_ok);
  wire bcd_mem = is_decimal_subtract_extend && f_rm;
  wire src_rd = bcd_mem || (is_sub && sub_to_reg && (ea_memalt || ea_pc));
  wire dst_mem = bcd_mem || (is_scc && f_mode != `DSS_MODE_DREG) || (is_sub && !sub_to_reg);
  wire [31:0] src_pick = !is_sub ? d_r[f_rlo] : !sub_to_reg ? d_r[f_rhi] :
                         f_mode == `DSS_MODE_DREG ? d_r[f_rlo] :
                         f_mode == `DSS_MODE_AREG ? a_r[f_rlo] : ea_val_r;
  wire [31:0] dst_pick = d_r[f_rhi];
  wire [2:0] wr_idx = is_scc ? f_rlo : f_rhi;

  // --------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------
  // packed decimal digits with extend
  wire [4:0] bcd_lo_raw = {1'b0, op_d_r[3:0]} - {1'b0, op_s_r[3:0]} - {4'h0, ccr_r.x};
  wire bcd_lb = bcd_lo_raw[4];
  wire [4:0] bcd_lo = bcd_lb ? bcd_lo_raw - `DSS_BCD_ADJ : bcd_lo_raw;
  wire [4:0] bcd_hi_raw = {1'b0, op_d_r[7:4]} - {1'b0, op_s_r[7:4]} - {4'h0, bcd_lb};
  wire bcd_borrow = bcd_hi_raw[4];
  wire [4:0] bcd_hi = bcd_borrow ? bcd_hi_raw - `DSS_BCD_ADJ : bcd_hi_raw;
  wire [7:0] bcd_res = {bcd_hi[3:0], bcd_lo[3:0]};
  // operands left-aligned so one subtractor serves every size
  wire [4:0] sh = sz == `DSS_SZ_BYTE ? 5'd24 : sz == `DSS_SZ_WORD ? 5'd16 : 5'd0;
  wire [31:0] sub_d = op_d_r << sh;
  wire [31:0] sub_s = op_s_r << sh;
  wire [32:0] sub_diff = {1'b0, sub_d} - {1'b0, sub_s};
  wire sub_v = (sub_d[31] != sub_s[31]) && (sub_diff[31] != sub_d[31]);
  wire [31:0] sub_res = sub_diff[31:0] >> sh;
  wire [31:0] scc_res = dss_cond(instr_r[`DSS_F_COND], ccr_r) ? 32'h0000_00ff : 32'h0;
  wire [31:0] alu_res = is_decimal_subtract_extend ? {24'h0, bcd_res} : is_scc ? scc_res : sub_res;

  // --------------------------------------------------------------
  // wishbone decode
  // --------------------------------------------------------------
  wire idle = st_r == dss_pkg::ST_IDLE;
  wire calc = st_r == dss_pkg::ST_CALC;
  wire wb_req = i_wb_cyc && i_wb_stb && !ack_r;
  // config writes only land while idle so software cannot race an op
  wire wb_wr = wb_req && i_wb_we && idle;
  wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [2:0] idx = i_wb_adr[4:2];
  wire hit_d = i_wb_adr[7:5] == `DSS_DREG_PAGE;
  wire hit_a = i_wb_adr[7:5] == `DSS_AREG_PAGE;
  wire start = wb_wr && i_wb_adr == `DSS_OFF_INSTR;
  wire [31:0] rd_val =
    i_wb_adr == `DSS_OFF_INSTR ? {16'h0, instr_r} :
    i_wb_adr == `DSS_OFF_STATUS ? {30'h0, err_r, !idle} :
    i_wb_adr == `DSS_OFF_CCR ? {27'h0, ccr_r} :
    i_wb_adr == `DSS_OFF_EA_VAL ? ea_val_r :
    i_wb_adr == `DSS_OFF_EA_ADDR ? ea_addr_r :
    i_wb_adr == `DSS_OFF_RESULT ? res_r :
    hit_d ? d_r[idx] : hit_a ? a_r[idx] : 32'h0;
  // source address decremented first, destination after the source read
  wire a_dec_src = st_r == dss_pkg::ST_EXEC && bcd_mem;
  wire a_dec_dst = st_r == dss_pkg::ST_RD_SRC && i_mem_ack && is_decimal_subtract_extend;
  wire [2:0] a_dec_idx = a_dec_src ? f_rlo : f_rhi;
  wire d_calc_wr = calc && !dst_mem;

  assign o_wb_dat = wb_dat_r;
  assign o_wb_ack = ack_r;
  assign o_mem = mem_r;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // single-cycle ack, dropped the cycle after
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_r <= 1'b0;
      wb_dat_r <= `DSS_WORD_RST;
    end else begin
      ack_r <= wb_req;
      wb_dat_r <= (wb_req && !i_wb_we) ? rd_val : `DSS_WORD_RST;
    end
  end

  // instruction and operand helpers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      instr_r <= `DSS_INSTR_RST;
      ea_val_r <= `DSS_WORD_RST;
      ea_addr_r <= `DSS_WORD_RST;
    end else if (wb_wr) begin
      if (i_wb_adr == `DSS_OFF_INSTR)
        instr_r <= (instr_r & ~wmask[15:0]) | (i_wb_dat[15:0] & wmask[15:0]);
      if (i_wb_adr == `DSS_OFF_EA_VAL)
        ea_val_r <= (ea_val_r & ~wmask) | (i_wb_dat & wmask);
      if (i_wb_adr == `DSS_OFF_EA_ADDR)
        ea_addr_r <= (ea_addr_r & ~wmask) | (i_wb_dat & wmask);
    end
  end

  // data registers: software when idle, result write in calc
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 8; i++) d_r[i] <= `DSS_WORD_RST;
    end else if (wb_wr && hit_d) begin
      d_r[idx] <= (d_r[idx] & ~wmask) | (i_wb_dat & wmask);
    end else if (d_calc_wr) begin
      d_r[wr_idx] <= dss_merge(d_r[wr_idx], alu_res, sz);
    end
  end

  // address registers: software when idle, byte predecrement
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 8; i++) a_r[i] <= `DSS_WORD_RST;
    end else if (wb_wr && hit_a) begin
      a_r[idx] <= (a_r[idx] & ~wmask) | (i_wb_dat & wmask);
    end else if (a_dec_src || a_dec_dst) begin
      a_r[a_dec_idx] <= a_r[a_dec_idx] - 32'h1;
    end
  end

  // condition flags
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ccr_r <= `DSS_CCR_RST;
    end else if (wb_wr && i_wb_adr == `DSS_OFF_CCR) begin
      if (i_wb_sel[0]) ccr_r <= i_wb_dat[4:0];
    end else if (calc && is_decimal_subtract_extend) begin
      ccr_r.c <= bcd_borrow;
      ccr_r.x <= bcd_borrow;
      // zero only ever cleared, chains stay valid
      if (bcd_res != 8'h00) ccr_r.z <= 1'b0;
    end else if (calc && is_sub) begin
      ccr_r.n <= sub_diff[31];
      ccr_r.z <= sub_diff[31:0] == 32'h0;
      ccr_r.v <= sub_v;
      ccr_r.c <= sub_diff[32];
      ccr_r.x <= sub_diff[32];
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= dss_pkg::ST_IDLE;
      mem_r <= '0;
      op_s_r <= `DSS_WORD_RST;
      op_d_r <= `DSS_WORD_RST;
      res_r <= `DSS_WORD_RST;
      err_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end else begin
      unique case (st_r)
        dss_pkg::ST_IDLE: begin
          if (start) begin
            err_r <= 1'b0;
            st_r <= dss_pkg::ST_EXEC;
          end
        end
        dss_pkg::ST_EXEC: begin
          op_s_r <= src_pick;
          op_d_r <= dst_pick;
          rd_seen_r <= 1'b0;
          mem_r.size <= sz;
          mem_r.we <= 1'b0;
          if (!legal) begin
            err_r <= 1'b1;
            st_r <= dss_pkg::ST_IDLE;
          end else if (src_rd) begin
            mem_r.req <= 1'b1;
            mem_r.addr <= is_decimal_subtract_extend ? a_r[f_rlo] - 32'h1 : ea_addr_r;
            st_r <= dss_pkg::ST_RD_SRC;
          end else if (dst_mem) begin
            // read of the target: subtract operand, or dummy read of the set byte target
            mem_r.req <= 1'b1;
            mem_r.addr <= ea_addr_r;
            st_r <= dss_pkg::ST_RD_DST;
          end else begin
            st_r <= dss_pkg::ST_CALC;
          end
        end
        dss_pkg::ST_RD_SRC: begin
          if (i_mem_ack) begin
            op_s_r <= i_mem_rdata;
            if (is_decimal_subtract_extend) begin
              mem_r.addr <= a_r[f_rhi] - 32'h1;
              st_r <= dss_pkg::ST_RD_DST;
            end else begin
              mem_r.req <= 1'b0;
              st_r <= dss_pkg::ST_CALC;
            end
          end
        end
        dss_pkg::ST_RD_DST: begin
          if (i_mem_ack) begin
            op_d_r <= i_mem_rdata;
            rd_seen_r <= 1'b1;
            mem_r.req <= 1'b0;
            st_r <= dss_pkg::ST_CALC;
          end
        end
        dss_pkg::ST_CALC: begin
          res_r <= alu_res;
          if (dst_mem) begin
            // address still holds the decremented destination (decimal) or ea_addr_r (set byte, subtract)
            mem_r.req <= 1'b1;
            mem_r.we <= 1'b1;
            mem_r.wdata <= alu_res;
            st_r <= dss_pkg::ST_WRITE;
          end else begin
            st_r <= dss_pkg::ST_IDLE;
          end
        end
        dss_pkg::ST_WRITE: begin
          if (i_mem_ack) begin
            mem_r.req <= 1'b0;
            mem_r.we <= 1'b0;
            st_r <= dss_pkg::ST_IDLE;
          end
        end
        default: st_r <= dss_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking dss_cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_src_done;
    st_r == dss_pkg::ST_RD_SRC && i_mem_ack && is_decimal_subtract_extend;
  endsequence
  sequence s_dst_read;
    st_r == dss_pkg::ST_RD_DST && o_mem.req && !o_mem.we && o_mem.addr == a_r[f_rhi];
  endsequence

  a_bcd_result: assert property (
    (calc && is_decimal_subtract_extend && !dst_mem) |=> d_r[f_rhi][7:0] == $past(bcd_res))
    else $error("decimal result not written to destination");
  a_bcd_flags: assert property (
    (calc && is_decimal_subtract_extend) |=> ccr_r.x == ccr_r.c && ccr_r.c == $past(bcd_borrow))
    else $error("decimal borrow flags wrong");
  a_bcd_zero_keep: assert property (
    (calc && is_decimal_subtract_extend) |=> ccr_r.z == ($past(ccr_r.z) && $past(bcd_res) == 8'h00))
    else $error("decimal zero flag wrong");
  a_bcd_predec_src: assert property (
    (st_r == dss_pkg::ST_EXEC && bcd_mem) |=>
      st_r == dss_pkg::ST_RD_SRC && o_mem.addr == a_r[f_rlo])
    else $error("source predecrement read missing");
  a_bcd_mem_order: assert property (s_src_done |=> s_dst_read)
    else $error("destination read did not follow source");
  a_scc_flags_kept: assert property ((calc && is_scc) |=> $stable(ccr_r))
    else $error("condition set changed flags");
  a_scc_read_first: assert property (
    (st_r == dss_pkg::ST_WRITE && is_scc) |-> rd_seen_r)
    else $error("condition write without prior read");
  a_scc_bad_mode: assert property (
    (st_r == dss_pkg::ST_EXEC && is_scc && !scc_ok) |=> err_r && idle)
    else $error("illegal condition destination accepted");
  a_sub_byte_an: assert property (
    (st_r == dss_pkg::ST_EXEC && is_sub && sub_to_reg && byte_an) |=> err_r ##1 !mem_r.req)
    else $error("byte subtract from address register accepted");
  a_sub_flags: assert property (
    (calc && is_sub) |=> ccr_r.x == ccr_r.c && ccr_r.z == ($past(sub_diff[31:0]) == 32'h0))
    else $error("subtract flags wrong");

endmodule : dss_exec_unit

// ### tb/decimal_sub_setcond_sub_exec_bench.sv
`timescale 1ns/100ps
`include "dss_defines.svh"
module decimal_sub_setcond_sub_exec_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, mrd = 32'h0;
  logic ack, mack = 1'b0;
  dss_pkg::dss_mem_req_t mem;
  int fail_count = 0;
  int checks_done = 0;
  int cyc_n = 0;
  int dly = 0;
  int rx, ry, rn, w;
  logic [31:0] seed = 32'h7da4;
  logic [31:0] mem_m [logic [31:0]];
  logic [32:0] acc_q [$];
  logic [31:0] wd_q [$];
  logic [31:0] q, st, s, d, ea, mk;
  logic [4:0] cc;
  logic [36:0] m;
  logic [8:0] bm;

  always #12.5 clk = ~clk;

  dss_exec_unit dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_mem(mem), .i_mem_rdata(mrd), .i_mem_ack(mack));

  // ------------------------------------------------------------
  // model helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // decimal subtract on two packed digits, borrow on top
  function automatic logic [8:0] bcd(input logic [7:0] sv, input logic [7:0] dv, input logic x);
    int t;
    t = dv[7:4] * 10 + dv[3:0] - sv[7:4] * 10 - sv[3:0] - x;
    if (t < 0) return {1'b1, 4'((t + 100) / 10), 4'((t + 100) % 10)};
    return {1'b0, 4'(t / 10), 4'(t % 10)};
  endfunction : bcd

  // all sixteen tests from {x,n,z,v,c}, indexed by condition code
  function automatic logic cond(input logic [3:0] c, input logic [4:0] f);
    logic n, z, v, cy;
    logic [15:0] t;
    {n, z, v, cy} = f[3:0];
    t = {z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), n, ~n, v, ~v, z, ~z, cy, ~cy,
      cy | z, ~cy & ~z, 1'b0, 1'b1};
    return t[c];
  endfunction : cond

  // binary subtract at width w: {x,n,z,v,c,result}
  function automatic logic [36:0] subm(input logic [31:0] dv, input logic [31:0] sv, input int wd);
    logic [31:0] k, r;
    logic c, v;
    k = (wd == 32) ? 32'hffff_ffff : (32'h1 << wd) - 32'h1;
    r = (dv - sv) & k;
    c = (sv & k) > (dv & k);
    v = (dv[wd-1] != sv[wd-1]) && (r[wd-1] != dv[wd-1]);
    return {c, r[wd-1], r == 32'h0, v, c, r};
  endfunction : subm

  // ------------------------------------------------------------
  // memory side: random latency, read data scrambled outside acks
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (mack || !mem.req) begin
      mack <= 1'b0;
      mrd <= xs();
      dly <= int'(xs() % 4);
    end else if (dly > 0) begin
      dly <= dly - 1;
      mrd <= xs();
    end else begin
      mack <= 1'b1;
      acc_q.push_back({mem.we, mem.addr});
      if (mem.we) wd_q.push_back(mem.wdata);
      if (mem.we) mem_m[mem.addr] = mem.wdata;
      mrd <= mem_m.exists(mem.addr) ? mem_m[mem.addr] : 32'h0;
    end
  end

  // hang guard, generous against the expected thousand-odd cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  // wide enough to keep the write flag above a 32-bit access address
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= dv;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n < 50), 32'h1, "bus ack");
  endtask : wb

  // start an opcode and poll busy, leaving status in st
  task automatic run(input logic [15:0] op);
    int n;
    acc_q.delete();
    wd_q.delete();
    wb(1'b1, `DSS_OFF_INSTR, {16'h0, op});
    n = 0;
    do begin
      wb(1'b0, `DSS_OFF_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    st = q;
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `DSS_OFF_CCR, 32'h0);
    chk(q, 32'h0, "ccr reset");
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("test reset_map done");
    // decimal pairs in registers and in predecremented memory
    for (int i = 0; i < 16; i++) begin
      rx = int'(xs() % 8);
      ry = (rx + 1 + int'(xs() % 7)) % 8;
      s = (xs() & 32'hffff_ff00) | {24'h0, 4'(xs() % 10), 4'(xs() % 10)};
      d = (xs() & 32'hffff_ff00) | {24'h0, 4'(xs() % 10), 4'(xs() % 10)};
      cc = 5'(xs());
      bm = bcd(s[7:0], d[7:0], cc[4]);
      wb(1'b1, `DSS_OFF_CCR, {27'h0, cc});
      if (i < 12) begin
        wb(1'b1, 8'h40 + 8'(4 * rx), s);
        wb(1'b1, 8'h40 + 8'(4 * ry), d);
        run(16'h8100 | 16'(ry << 9) | 16'(rx));
        wb(1'b0, 8'h40 + 8'(4 * ry), 32'h0);
        chk(q, {d[31:8], bm[7:0]}, "decimal reg");
      end else begin
        wb(1'b1, 8'h60 + 8'(4 * rx), 32'h101 + 32'(16 * rx));
        wb(1'b1, 8'h60 + 8'(4 * ry), 32'h101 + 32'(16 * ry));
        mem_m[32'h100 + 32'(16 * rx)] = {24'h0, s[7:0]};
        mem_m[32'h100 + 32'(16 * ry)] = {24'h0, d[7:0]};
        run(16'h8108 | 16'(ry << 9) | 16'(rx));
        chk(32'(acc_q.size()), 32'h3, "decimal mem count");
        chk(acc_q[0], {1'b0, 32'h100 + 32'(16 * rx)}, "decimal src read");
        chk(acc_q[1], {1'b0, 32'h100 + 32'(16 * ry)}, "decimal dst read");
        chk(acc_q[2], {1'b1, 32'h100 + 32'(16 * ry)}, "decimal write");
        chk(wd_q[0] & 32'hff, {24'h0, bm[7:0]}, "decimal mem data");
        wb(1'b0, 8'h60 + 8'(4 * rx), 32'h0);
        chk(q, 32'h100 + 32'(16 * rx), "source predecrement");
      end
      wb(1'b0, `DSS_OFF_CCR, 32'h0);
      chk(q, {27'h0, bm[8], cc[3], cc[2] & (bm[7:0] == 8'h0), cc[1], bm[8]},
        "decimal flags");
    end
    $display("test decimal done");
    // every condition code, even codes to a data register, odd codes to memory
    for (int c = 0; c < 16; c++) begin
      rn = int'(xs() % 8);
      d = xs();
      cc = 5'(xs());
      ea = 32'h200 + 32'(4 * c);
      wb(1'b1, 8'h40 + 8'(4 * rn), d);
      wb(1'b1, `DSS_OFF_CCR, {27'h0, cc});
      wb(1'b1, `DSS_OFF_EA_ADDR, ea);
      run(16'h50c0 | 16'(c << 8) | (c % 2 ? 16'h10 : 16'(rn)));
      if (c % 2) begin
        chk(acc_q[0], {1'b0, ea}, "set byte read first");
        chk(acc_q[1], {1'b1, ea}, "set byte write after");
        chk(32'(mem.size), 32'h0, "set byte size");
        chk(wd_q[0] & 32'hff, cond(4'(c), cc) ? 32'hff : 32'h0, "set byte mem");
      end else begin
        wb(1'b0, 8'h40 + 8'(4 * rn), 32'h0);
        chk(q, {d[31:8], cond(4'(c), cc) ? 8'hff : 8'h00}, "set byte reg");
      end
      wb(1'b0, `DSS_OFF_CCR, 32'h0);
      chk(q, {27'h0, cc}, "set byte flags kept");
    end
    $display("test set_on_condition done");
    // illegal: set byte to An, to immediate, byte subtract from An
    wb(1'b1, 8'h40, 32'h1234_5678);
    for (int k = 0; k < 3; k++) begin
      run(k == 0 ? 16'h50c8 : (k == 1 ? 16'h50fc : 16'h9008));
      chk(st[1], 32'h1, "illegal flagged");
      chk(32'(acc_q.size()), 32'h0, "illegal no traffic");
    end
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h1234_5678, "illegal no write");
    $display("test illegal done");
    // subtract into register from Dn, immediate and memory sources, then into memory
    for (int j = 0; j < 12; j++) begin
      w = 8 << (j % 3);
      rn = int'(xs() % 7) + 1;
      d = xs();
      s = (j == 4) ? d : xs();
      m = subm(d, s, w);
      mk = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
      wb(1'b1, 8'h40 + 8'(4 * rn), d);
      wb(1'b1, 8'h40, s);
      wb(1'b1, `DSS_OFF_EA_VAL, s);
      wb(1'b1, `DSS_OFF_EA_ADDR, 32'h300);
      mem_m[32'h300] = (j < 9) ? s : d;
      if (j < 9) begin
        run(16'h9000 | 16'(rn << 9) | 16'((j % 3) << 6) |
          ((j / 3) == 1 ? 16'h3c : 16'((j / 3) * 8)));
        wb(1'b0, 8'h40 + 8'(4 * rn), 32'h0);
        chk(q, (d & ~mk) | m[31:0], "subtract to reg");
      end else begin
        wb(1'b1, 8'h40 + 8'(4 * rn), s);
        run(16'h9110 | 16'(rn << 9) | 16'((j % 3) << 6));
        chk(acc_q[0], {1'b0, 32'h300}, "subtract mem read");
        chk(acc_q[1], {1'b1, 32'h300}, "subtract mem write");
        chk(wd_q[0] & mk, m[31:0], "subtract to mem");
      end
      chk(st[1], 32'h0, "legal source");
      wb(1'b0, `DSS_OFF_CCR, 32'h0);
      chk(q, {27'h0, m[36:32]}, "subtract flags");
    end
    $display("test subtract done");
    print_verdict();
  end
endmodule : decimal_sub_setcond_sub_exec_bench
